/* File: inc/spc_map.svh */
// offsets, field positions, reset values and counts of the serial port config bank
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_ADDR_CONFIG 13'h000
`define SPC_ADDR_REVISION 13'h002
`define SPC_ADDR_VARIANT 13'h003
`define SPC_ADDR_RB_SEL 13'h004
`define SPC_CFG_SEP_OUT 7
`define SPC_CFG_LSB_FIRST 6
`define SPC_CFG_SOFT_RST 5
`define SPC_RB_SEL_BIT 0
`define SPC_CFG_RESET 3'h0
`define SPC_RB_SEL_RESET 1'h0
`define SPC_INSTR_LAST 5'h0f
`define SPC_BYTE_LAST 5'h07
`define SPC_WLEN_STREAM 2'h3
`define SPC_PIN_RESET 4'h2
`endif

/* File: inc/spc_pkg.sv */
// types shared by the serial port config bank
package spc_pkg;
   typedef struct packed {
      logic rd;
      logic [1:0] wlen;
      logic [12:0] addr;
   } spc_instr_t;

   typedef struct packed {
      logic en;
      logic [12:0] addr;
      logic [7:0] data;
   } spc_wr_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_INSTR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_DONE = 4'b1000
   } spc_state_t;
endpackage

/* File: rtl/spc_serial_port_config_regs.sv */
// serial control port slave with the configuration and identification register bank
`include "spc_map.svh"

// Function
// R1: with the pin-mode bit clear, reads go out on the two-way data pin and the serial out pin floats.
// R2: with the pin-mode bit set, reads go out on the serial out pin and writes come in on the data pin.
// R3: with the order bit clear, bits shift msb first and the address steps down per byte.
// R4: with the order bit set, bits shift lsb first and the address steps up per byte.
// R5: in i2c mode the order and address-direction bit has no effect.
// R6: writing one to the soft-reset bit restores the other registers to defaults.
// R7: the soft-reset bit clears itself on the first serial clock after its write completes.
// R8: soft reset leaves the configuration register itself unchanged.
// R9: the host writes the low nibble of the configuration byte as the mirror of the high nibble.
// R10: a read-only register reports the silicon revision.
// R11: a read-only register holds the fixed variant identifier.
// R12: bit 0 of the readback select register picks buffer (0) or active (1) registers for reads; here it only drives O_READBACK_ACTIVE, reads ignore it.
// R13: writes to unused bits are ignored and those bits read back as zero.
module spc_serial_port_config_regs
   import spc_pkg::*;
#(
   parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
   parameter logic [7:0] VARIANT_ID = 8'h5a // arbitrary value
) (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_SCLK,
   input wire logic I_CS_N,
   input wire logic I_SDIO,
   output logic O_SDIO,
   output logic O_SDIO_OE,
   output logic O_SERIAL_OUT_PIN,
   output logic O_SERIAL_OUT_PIN_OE,
   input wire logic I_I2C_MODE,
   output logic O_SOFT_RESET,
   output logic O_READBACK_ACTIVE
);

   // pin synchronisers: a change counts once stages two and three agree
   logic [3:0] pin_raw;
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] lvl_q;
   logic sclk_prev_q;

   assign pin_raw = {I_I2C_MODE, I_SDIO, I_CS_N, I_SCLK};

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         s1_q <= `SPC_PIN_RESET;
         s2_q <= `SPC_PIN_RESET;
         s3_q <= `SPC_PIN_RESET;
         lvl_q <= `SPC_PIN_RESET;
         sclk_prev_q <= 1'b0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
         sclk_prev_q <= lvl_q[0];
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;
   logic sdi;
   logic i2c_mode;

   assign sclk_rise = lvl_q[0] & ~sclk_prev_q;
   assign sclk_fall = ~lvl_q[0] & sclk_prev_q;
   assign cs_active = ~lvl_q[1];
   assign sdi = lvl_q[2];
   assign i2c_mode = lvl_q[3];

   // configuration bits 7..5 and readback select
   logic [2:0] cfg_q;
   logic rb_sel_q;
   logic soft_pend_q;
   logic soft_rst_q;
   logic eff_lsb;

   assign eff_lsb = cfg_q[`SPC_CFG_LSB_FIRST - 5] & ~i2c_mode; // R5

   // register read mux
   function automatic logic [7:0] rd_byte(input logic [12:0] a);
      logic [7:0] v;
      v = 8'h00; // R13
      unique case (a)
         `SPC_ADDR_CONFIG: v = {cfg_q, 1'b0, 1'b0, cfg_q[0], cfg_q[1], cfg_q[2]}; // R13
         `SPC_ADDR_REVISION: v = REVISION_ID; // R10
         `SPC_ADDR_VARIANT: v = VARIANT_ID; // R11
         `SPC_ADDR_RB_SEL: v = {7'h00, rb_sel_q}; // R12
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // frame engine
   spc_state_t state_q;
   spc_instr_t ins_q;
   spc_wr_t wr_q;
   logic [15:0] sh_q;
   logic [15:0] sh_d;
   logic [4:0] cnt_q;
   logic [1:0] left_q;
   logic [7:0] tx_q;
   logic frame_lsb_q;
   logic [12:0] next_addr;
   logic [7:0] rx_byte;
   spc_instr_t ins_d;

   // order is frozen for the whole frame so a config write cannot split a byte
   assign sh_d = frame_lsb_q ? {sdi, sh_q[15:1]} : {sh_q[14:0], sdi}; // R3 R4
   assign rx_byte = frame_lsb_q ? sh_d[15:8] : sh_d[7:0];
   assign ins_d = spc_instr_t'(sh_d);
   assign next_addr = frame_lsb_q ? ins_q.addr + 13'h0001 : ins_q.addr - 13'h0001; // R3 R4

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         state_q <= ST_IDLE;
         ins_q <= '0;
         wr_q <= '0;
         sh_q <= 16'h0000;
         cnt_q <= 5'h00;
         left_q <= 2'h0;
         tx_q <= 8'h00;
         frame_lsb_q <= 1'b0;
      end else begin
         wr_q.en <= 1'b0;
         if (!cs_active) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            frame_lsb_q <= eff_lsb;
         end else begin
            unique case (state_q)
               ST_IDLE, ST_INSTR: begin
                  if (sclk_rise) begin
                     sh_q <= sh_d;
                     if (cnt_q == `SPC_INSTR_LAST) begin
                        cnt_q <= 5'h00;
                        ins_q <= ins_d;
                        left_q <= ins_d.wlen;
                        tx_q <= rd_byte(ins_d.addr);
                        state_q <= ST_DATA;
                     end else begin
                        cnt_q <= cnt_q + 5'h01;
                        state_q <= ST_INSTR;
                     end
                  end
               end
               ST_DATA: begin
                  if (sclk_rise) begin
                     sh_q <= sh_d;
                     if (cnt_q == `SPC_BYTE_LAST) begin
                        cnt_q <= 5'h00;
                        if (!ins_q.rd) begin
                           wr_q.en <= 1'b1;
                           wr_q.addr <= ins_q.addr;
                           wr_q.data <= rx_byte;
                        end
                        ins_q.addr <= next_addr;
                        tx_q <= rd_byte(next_addr);
                        if (left_q != `SPC_WLEN_STREAM) begin
                           left_q <= left_q - 2'h1;
                           if (left_q == 2'h0) begin
                              state_q <= ST_DONE;
                           end
                        end
                     end else begin
                        cnt_q <= cnt_q + 5'h01;
                     end
                  end else if (sclk_fall && ins_q.rd) begin
                     tx_q <= frame_lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
                  end
               end
               ST_DONE: begin
                  // extra clocks past the byte count are ignored until chip select rises
                  state_q <= ST_DONE;
               end
            endcase
         end
      end
   end

   // read data drive: launched on the falling serial clock, sampled by the host late in the high phase
   logic rd_phase;
   logic out_bit;

   assign rd_phase = (state_q == ST_DATA) && ins_q.rd;
   assign out_bit = frame_lsb_q ? tx_q[0] : tx_q[7];

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         O_SDIO <= 1'b0;
         O_SDIO_OE <= 1'b0;
         O_SERIAL_OUT_PIN <= 1'b0;
         O_SERIAL_OUT_PIN_OE <= 1'b0;
      end else if (!cs_active) begin
         O_SDIO_OE <= 1'b0;
         O_SERIAL_OUT_PIN_OE <= 1'b0;
      end else if (sclk_fall) begin
         O_SDIO <= out_bit;
         O_SERIAL_OUT_PIN <= out_bit;
         O_SDIO_OE <= rd_phase & ~cfg_q[`SPC_CFG_SEP_OUT - 5]; // R1
         O_SERIAL_OUT_PIN_OE <= rd_phase & cfg_q[`SPC_CFG_SEP_OUT - 5]; // R2
      end
   end

   // register bank and soft reset
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         cfg_q <= `SPC_CFG_RESET;
         rb_sel_q <= `SPC_RB_SEL_RESET;
         soft_pend_q <= 1'b0;
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= 1'b0;
         // write commit lags the rise by a cycle, so this waits for the next clock
         if (soft_pend_q && sclk_rise) begin
            soft_pend_q <= 1'b0;
            cfg_q[`SPC_CFG_SOFT_RST - 5] <= 1'b0; // R7
            rb_sel_q <= `SPC_RB_SEL_RESET; // R6 R8
            soft_rst_q <= 1'b1; // R6
         end
         if (wr_q.en) begin
            unique case (wr_q.addr)
               `SPC_ADDR_CONFIG: begin
                  // low nibble is only a mirror and bit 4 is unused
                  cfg_q <= wr_q.data[7:5]; // R9 R13
                  soft_pend_q <= wr_q.data[`SPC_CFG_SOFT_RST]; // R6
               end
               `SPC_ADDR_RB_SEL: rb_sel_q <= wr_q.data[`SPC_RB_SEL_BIT]; // R12 R13
               default: ;
            endcase
         end
      end
   end

   assign O_SOFT_RESET = soft_rst_q;
   assign O_READBACK_ACTIVE = rb_sel_q; // R12
endmodule

/* File: verification/spc_host_model.sv */
// host serial controller model on the far side of the config bank link
module spc_host_model (
   input wire logic i_clock,
   input wire logic i_sdio,
   input wire logic i_sdio_oe,
   input wire logic i_sop,
   input wire logic i_sop_oe,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdio
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdio = 1'b0;
   end
   // sample late in the high phase: read data lands 4-5 cycles after a fall
   task automatic bit_io(input logic b, input logic sep, output logic r);
      o_sdio = b;
      repeat (4) @(negedge i_clock);
      o_sclk = 1'b1;
      repeat (3) @(negedge i_clock);
      r = sep ? (i_sop_oe ? i_sop : 1'bx) : (i_sdio_oe ? i_sdio : 1'bx);
      @(negedge i_clock);
      o_sclk = 1'b0;
   endtask
   // one byte frame; a released data line toggles so a stale value never passes
   task automatic xfer(input logic rd, input logic lsb, input logic sep,
                       input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
      logic [15:0] w;
      logic r;
      w = {rd, 2'h0, a};
      o_cs_n = 1'b0;
      repeat (4) @(negedge i_clock);
      for (int i = 0; i < 16; i++) begin
         bit_io(w[lsb ? i : 15 - i], sep, r);
      end
      for (int i = 0; i < 8; i++) begin
         bit_io(rd ? ~o_sdio : wd[lsb ? i : 7 - i], sep, r);
         q[lsb ? i : 7 - i] = r;
      end
      repeat (4) @(negedge i_clock);
      o_cs_n = 1'b1;
      repeat (8) @(negedge i_clock);
   endtask
endmodule

/* File: verification/spc_serial_port_config_regs_assertions.sv */
// concurrent checks on the config bank ports
module spc_serial_port_config_regs_assertions (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_SCLK,
   input wire logic I_CS_N,
   input wire logic O_SDIO,
   input wire logic O_SDIO_OE,
   input wire logic O_SERIAL_OUT_PIN,
   input wire logic O_SERIAL_OUT_PIN_OE,
   input wire logic O_SOFT_RESET,
   input wire logic O_READBACK_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   property p_one_pin; !(O_SDIO_OE && O_SERIAL_OUT_PIN_OE); endproperty
   a_one_pin: assert property (p_one_pin) else $error("both data pins driven");
   property p_same_bit; O_SERIAL_OUT_PIN_OE |-> O_SERIAL_OUT_PIN == O_SDIO; endproperty
   a_same_bit: assert property (p_same_bit) else $error("out pin bit differs");
   property p_sdio_frame; O_SDIO_OE |-> !$past(I_CS_N, 6); endproperty
   a_sdio_frame: assert property (p_sdio_frame) else $error("data pin driven idle");
   property p_sop_frame; O_SERIAL_OUT_PIN_OE |-> !$past(I_CS_N, 6); endproperty
   a_sop_frame: assert property (p_sop_frame) else $error("out pin driven idle");
   property p_soft_pulse; O_SOFT_RESET |=> !O_SOFT_RESET; endproperty
   a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");
   property p_soft_rb; O_SOFT_RESET |-> ##[0:1] !O_READBACK_ACTIVE; endproperty
   a_soft_rb: assert property (p_soft_rb) else $error("select kept on soft reset");
   property p_soft_sclk; $rose(O_SOFT_RESET) |-> $past(I_SCLK, 3); endproperty
   a_soft_sclk: assert property (p_soft_sclk) else $error("soft reset off clock");
   property p_rb_chg; $changed(O_READBACK_ACTIVE) |-> !$past(I_CS_N, 8); endproperty
   a_rb_chg: assert property (p_rb_chg) else $error("select moved idle");
   c_soft: cover property (O_SOFT_RESET);
   c_sop: cover property ($rose(O_SERIAL_OUT_PIN_OE));
   c_sdio: cover property ($rose(O_SDIO_OE));
endmodule
bind spc_serial_port_config_regs spc_serial_port_config_regs_assertions i_chk (
   .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N), .O_SDIO(O_SDIO),
   .O_SDIO_OE(O_SDIO_OE), .O_SERIAL_OUT_PIN(O_SERIAL_OUT_PIN),
   .O_SERIAL_OUT_PIN_OE(O_SERIAL_OUT_PIN_OE), .O_SOFT_RESET(O_SOFT_RESET),
   .O_READBACK_ACTIVE(O_READBACK_ACTIVE));

/* File: verification/spc_serial_port_config_regs_tb.sv */
// self-checking bench for the serial port config bank
`include "spc_map.svh"
module spc_serial_port_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] REV = 8'h3c; // arbitrary value
   localparam logic [7:0] VAR = 8'h96; // arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic i2c = 1'b0;
   wire sclk, cs_n, hsdio;
   logic sdio, sdio_oe, sop, sop_oe, srst, rba;
   wire sdio_w = sdio_oe ? sdio : hsdio;
   int error_cnt = 0;
   int tests_run = 0;
   logic [7:0] d;
   logic [7:0] srst_cnt = 8'h00;
   always #50 clk = ~clk;
   always @(posedge clk) if (srst) srst_cnt <= srst_cnt + 8'h01;
   spc_serial_port_config_regs #(.REVISION_ID(REV), .VARIANT_ID(VAR)) i_dut (
      .I_CLOCK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SDIO(sdio_w),
      .O_SDIO(sdio), .O_SDIO_OE(sdio_oe), .O_SERIAL_OUT_PIN(sop),
      .O_SERIAL_OUT_PIN_OE(sop_oe), .I_I2C_MODE(i2c), .O_SOFT_RESET(srst),
      .O_READBACK_ACTIVE(rba));
   spc_host_model i_host (.i_clock(clk), .i_sdio(sdio), .i_sdio_oe(sdio_oe), .i_sop(sop),
      .i_sop_oe(sop_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(hsdio));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rd(input logic [12:0] a, input logic lsb, input logic sep, input logic [7:0] exp);
      i_host.xfer(1'b1, lsb, sep, a, 8'h00, d);
      chk(d, exp);
   endtask
   task wr(input logic [12:0] a, input logic lsb, input logic [7:0] v);
      i_host.xfer(1'b0, lsb, 1'b0, a, v, d);
   endtask
   task test_done;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      test_done;
   end
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(`SPC_ADDR_CONFIG, 1'b0, 1'b0, 8'h00);
      rd(`SPC_ADDR_REVISION, 1'b0, 1'b0, REV);
      rd(`SPC_ADDR_VARIANT, 1'b0, 1'b0, VAR);
      rd(`SPC_ADDR_RB_SEL, 1'b0, 1'b0, 8'h00);
      rd(13'h001, 1'b0, 1'b0, 8'h00);
      wr(`SPC_ADDR_VARIANT, 1'b0, 8'h00);
      rd(`SPC_ADDR_VARIANT, 1'b0, 1'b0, VAR);
      wr(`SPC_ADDR_CONFIG, 1'b0, 8'h18);
      rd(`SPC_ADDR_CONFIG, 1'b0, 1'b0, 8'h00);
      wr(`SPC_ADDR_RB_SEL, 1'b0, 8'hff);
      chk({7'h00, rba}, 8'h01);
      rd(`SPC_ADDR_RB_SEL, 1'b0, 1'b0, 8'h01);
      wr(`SPC_ADDR_CONFIG, 1'b0, 8'h81);
      rd(`SPC_ADDR_VARIANT, 1'b0, 1'b1, VAR);
      wr(`SPC_ADDR_CONFIG, 1'b0, 8'hc3);
      rd(`SPC_ADDR_CONFIG, 1'b1, 1'b1, 8'hc3);
      // order is latched while deselected, so let the mode settle first
      i2c = 1'b1;
      repeat (8) @(negedge clk);
      rd(`SPC_ADDR_VARIANT, 1'b0, 1'b1, VAR);
      i2c = 1'b0;
      repeat (8) @(negedge clk);
      wr(`SPC_ADDR_CONFIG, 1'b1, 8'he7);
      rd(`SPC_ADDR_RB_SEL, 1'b1, 1'b1, 8'h00);
      chk(srst_cnt, 8'h01);
      rd(`SPC_ADDR_CONFIG, 1'b1, 1'b1, 8'hc3);
      test_done;
   end
endmodule
